// ==== rtl/rss_defines.svh ====
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ==========================================================
// Register offsets
`define RSS_OFF_CTRL       8'h00
`define RSS_OFF_MAX        8'h04
`define RSS_OFF_SP_ACC     8'h08
`define RSS_OFF_SP_DEC     8'h0C
`define RSS_OFF_OUT_ACC    8'h10
`define RSS_OFF_OUT_DEC    8'h14
`define RSS_OFF_PANEL      8'h18
`define RSS_OFF_STATUS     8'h1C
`define RSS_OFF_STORED     8'h20
`define RSS_OFF_CMD        8'h24

// ==========================================================
// Control fields
`define RSS_CTRL_SEL_LSB   0
`define RSS_CTRL_SEL_MSB   1
`define RSS_CTRL_PANEL_BIT 2

// ==========================================================
// Reset values
`define RSS_RST_SEL        2'h0
`define RSS_RST_MAX        16'h05DC
`define RSS_RST_TIME       16'h0005
`define RSS_RST_PANEL      16'h0000

// ==========================================================
// Timing
`define RSS_CLK_NS         40
`define RSS_TICK_NS        1000000
`define RSS_TICK_CYCLES    (`RSS_TICK_NS / `RSS_CLK_NS)
`define RSS_MINUTE_MS      60000

`endif

// ==== rtl/rss_pkg.sv ====
`default_nettype none
package rss_pkg;
  typedef logic [15:0] rss_speed_t;
  typedef enum logic [0:0] {RSS_BOOT, RSS_LIVE} rss_phase_t;
endpackage : rss_pkg
`default_nettype wire

// ==== rtl/rss_ramp.sv ====
`timescale 1ns/10ps
`default_nettype none
module rss_ramp #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         en,
  input  wire logic [W-1:0] target,
  input  wire logic [15:0]  period_up,
  input  wire logic [15:0]  period_dn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] value
);
  if (W < 2 || W > 32) begin : g_bad_width
    $error("rss_ramp: W out of range");
  end

  logic [W-1:0] val_r;
  logic [W-1:0] val_nxt;
  logic [15:0]  cnt_r;
  logic [15:0]  cnt_nxt;
  logic [15:0]  period;

  // ==========================================================
  // One unit step per period+1 ticks
  always_comb begin
    val_nxt = val_r;
    cnt_nxt = cnt_r;
    period  = (target > val_r) ? period_up : period_dn;
    if (load) begin
      val_nxt = load_val;
      cnt_nxt = 16'h0000;
    end else if (!en || val_r == target) begin
      cnt_nxt = 16'h0000;
    end else if (tick) begin
      if (cnt_r >= period) begin
        cnt_nxt = 16'h0000;
        val_nxt = (target > val_r) ? val_r + 1'b1 : val_r - 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      val_r <= '0;
      cnt_r <= 16'h0000;
    end else begin
      val_r <= val_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign value = val_r;
endmodule : rss_ramp
`default_nettype wire

// ==== rtl/rss_top.sv ====
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rss_defines.svh"
module rss_top #(
  parameter int TICK_CYCLES  = `RSS_TICK_CYCLES,
  parameter int MINUTE_TICKS = `RSS_MINUTE_MS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        speed_up_input,
  input  wire logic        speed_down_input,
  input  wire logic        setpoint_clear_input,
  input  wire logic        forward_run_cmd,
  input  wire logic        reverse_run_cmd,
  input  wire logic        jog_operation,
  input  wire logic        closed_loop_process_control,
  input  wire logic [15:0] analog_speed_cmd,
  input  wire logic [15:0] nvm_stored_value,
  output logic      [2:0]  multi_speed_sel,
  output logic             nvm_write_strobe,
  output logic      [15:0] nvm_write_data,
  output logic      [15:0] speed_command,
  output logic      [15:0] output_speed
);
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("rss_top: TICK_CYCLES out of range");
  end
  if (MINUTE_TICKS < 1 || MINUTE_TICKS > 65535) begin : g_bad_minute
    $error("rss_top: MINUTE_TICKS out of range");
  end

  // ==========================================================
  // Bus slave
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  sel_r;
  logic [1:0]  sel_nxt;
  logic        panel_r;
  logic        panel_nxt;
  rss_pkg::rss_speed_t max_r, max_nxt, sp_acc_r, sp_acc_nxt, sp_dec_r, sp_dec_nxt;
  rss_pkg::rss_speed_t out_acc_r, out_acc_nxt, out_dec_r, out_dec_nxt, pnl_r, pnl_nxt;
  rss_pkg::rss_speed_t set_speed;
  rss_pkg::rss_speed_t stored_r;
  logic        addr_ok;

  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:8] == 24'h000000)
                   && (haddr[1:0] == 2'h0);

  always_comb begin
    wr_pend_nxt = addr_ok && hwrite;
    wr_addr_nxt = haddr[7:0];
    rdata_nxt   = 32'h00000000;
    sel_nxt     = sel_r;
    panel_nxt   = panel_r;
    max_nxt     = max_r;
    sp_acc_nxt  = sp_acc_r;
    sp_dec_nxt  = sp_dec_r;
    out_acc_nxt = out_acc_r;
    out_dec_nxt = out_dec_r;
    pnl_nxt     = pnl_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `RSS_OFF_CTRL: begin
          sel_nxt   = hwdata[`RSS_CTRL_SEL_MSB:`RSS_CTRL_SEL_LSB];
          panel_nxt = hwdata[`RSS_CTRL_PANEL_BIT];
        end
        `RSS_OFF_MAX:     max_nxt     = hwdata[15:0];
        `RSS_OFF_SP_ACC:  sp_acc_nxt  = hwdata[15:0];
        `RSS_OFF_SP_DEC:  sp_dec_nxt  = hwdata[15:0];
        `RSS_OFF_OUT_ACC: out_acc_nxt = hwdata[15:0];
        `RSS_OFF_OUT_DEC: out_dec_nxt = hwdata[15:0];
        `RSS_OFF_PANEL:   pnl_nxt     = hwdata[15:0];
        default: ;
      endcase
    end
    // Read data is latched in the address phase: zero wait states
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `RSS_OFF_CTRL:    rdata_nxt = {29'h00000000, panel_r, sel_r};
        `RSS_OFF_MAX:     rdata_nxt = {16'h0000, max_r};
        `RSS_OFF_SP_ACC:  rdata_nxt = {16'h0000, sp_acc_r};
        `RSS_OFF_SP_DEC:  rdata_nxt = {16'h0000, sp_dec_r};
        `RSS_OFF_OUT_ACC: rdata_nxt = {16'h0000, out_acc_r};
        `RSS_OFF_OUT_DEC: rdata_nxt = {16'h0000, out_dec_r};
        `RSS_OFF_PANEL:   rdata_nxt = {16'h0000, pnl_r};
        `RSS_OFF_STATUS:  rdata_nxt = {output_speed, set_speed};
        `RSS_OFF_STORED:  rdata_nxt = {16'h0000, stored_r};
        `RSS_OFF_CMD:     rdata_nxt = {16'h0000, speed_command};
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h00000000;
      sel_r     <= `RSS_RST_SEL;
      panel_r   <= 1'b0;
      max_r     <= `RSS_RST_MAX;
      sp_acc_r  <= `RSS_RST_TIME;
      sp_dec_r  <= `RSS_RST_TIME;
      out_acc_r <= `RSS_RST_TIME;
      out_dec_r <= `RSS_RST_TIME;
      pnl_r     <= `RSS_RST_PANEL;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
      sel_r     <= sel_nxt;
      panel_r   <= panel_nxt;
      max_r     <= max_nxt;
      sp_acc_r  <= sp_acc_nxt;
      sp_dec_r  <= sp_dec_nxt;
      out_acc_r <= out_acc_nxt;
      out_dec_r <= out_dec_nxt;
      pnl_r     <= pnl_nxt;
    end
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // Millisecond tick and mode decode
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic        tick;
  logic        remote_act;
  logic        store_mode;

  assign tick = (div_r == 16'(TICK_CYCLES - 1));
  always_comb begin
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_r <= 16'h0000;
    else          div_r <= div_nxt;
  end

  assign remote_act = (sel_r != 2'h0) && !jog_operation
                      && !closed_loop_process_control;
  assign store_mode = remote_act && (sel_r == 2'h1);

  // ==========================================================
  // Setpoint, storage and output ramps
  rss_pkg::rss_phase_t phase_r, phase_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        run_fell;
  logic [15:0] idle_r;
  logic [15:0] idle_nxt;
  logic        minute;
  logic        wr_nxt;
  rss_pkg::rss_speed_t stored_nxt, cmd_nxt, comp;
  logic [2:0]  msel_nxt;
  logic        sp_en;
  logic        sp_load;
  rss_pkg::rss_speed_t sp_load_val;
  logic [16:0] sum;

  assign run_fell = run_r && !forward_run_cmd && !reverse_run_cmd;
  assign minute   = tick && (idle_r == 16'(MINUTE_TICKS - 1));

  // Up and down together hold the setpoint; ramp runs even when stopped
  assign sp_en = remote_act && (speed_up_input ^ speed_down_input);
  // Clear and boot restore take priority over ramping
  always_comb begin
    sp_load     = 1'b0;
    sp_load_val = 16'h0000;
    if (phase_r == rss_pkg::RSS_BOOT) begin
      sp_load     = 1'b1;
      sp_load_val = (nvm_stored_value > max_r) ? max_r : nvm_stored_value;
    end else if (remote_act && setpoint_clear_input) begin
      sp_load = 1'b1;
    end else if (set_speed > max_r) begin
      sp_load     = 1'b1;
      sp_load_val = max_r;
    end
  end

  rss_ramp #(.W(16)) u_setpoint (
    .clk       (hclk),
    .rstn      (hresetn),
    .tick      (tick),
    .en        (sp_en),
    .target    (speed_up_input ? max_r : 16'h0000),
    .period_up (sp_acc_r),
    .period_dn (sp_dec_r),
    .load      (sp_load),
    .load_val  (sp_load_val),
    .value     (set_speed)
  );

  assign comp = panel_r ? pnl_r : analog_speed_cmd;
  assign sum  = {1'b0, remote_act ? set_speed : 16'h0000} + {1'b0, comp};

  always_comb begin
    phase_nxt  = rss_pkg::RSS_LIVE;
    run_nxt    = forward_run_cmd || reverse_run_cmd;
    idle_nxt   = idle_r;
    wr_nxt     = 1'b0;
    stored_nxt = stored_r;
    cmd_nxt    = sum[16] ? 16'hFFFF : sum[15:0];
    msel_nxt   = (sel_r == 2'h0) ? {speed_up_input, speed_down_input,
                                    setpoint_clear_input} : 3'h0;
    case (phase_r)
      rss_pkg::RSS_BOOT: begin
        stored_nxt = nvm_stored_value;
        idle_nxt   = 16'h0000;
      end
      rss_pkg::RSS_LIVE: begin
        // Ramp activity restarts the minute count; clear does not
        if (speed_up_input || speed_down_input) begin
          idle_nxt = 16'h0000;
        end else if (tick) begin
          idle_nxt = minute ? 16'h0000 : idle_r + 16'h0001;
        end
        if (store_mode && run_fell) begin
          wr_nxt = 1'b1;
        end else if (store_mode && minute && !speed_up_input && !speed_down_input
                     && set_speed != stored_r) begin
          wr_nxt = 1'b1;
        end
        if (wr_nxt) stored_nxt = set_speed;
      end
      default: phase_nxt = rss_pkg::RSS_BOOT;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r          <= rss_pkg::RSS_BOOT;
      run_r            <= 1'b0;
      idle_r           <= 16'h0000;
      stored_r         <= 16'h0000;
      nvm_write_strobe <= 1'b0;
      nvm_write_data   <= 16'h0000;
      speed_command    <= 16'h0000;
      multi_speed_sel  <= 3'h0;
    end else begin
      phase_r          <= phase_nxt;
      run_r            <= run_nxt;
      idle_r           <= idle_nxt;
      stored_r         <= stored_nxt;
      nvm_write_strobe <= wr_nxt;
      nvm_write_data   <= wr_nxt ? set_speed : nvm_write_data;
      speed_command    <= cmd_nxt;
      multi_speed_sel  <= msel_nxt;
    end
  end

  // Output ramp limits the actual rate when slower than the setpoint ramp
  rss_ramp #(.W(16)) u_output (
    .clk       (hclk),
    .rstn      (hresetn),
    .tick      (tick),
    .en        (1'b1),
    .target    (speed_command),
    .period_up (out_acc_r),
    .period_dn (out_dec_r),
    .load      (1'b0),
    .load_val  (16'h0000),
    .value     (output_speed)
  );

  // ==========================================================
  // Checks
  a_mspeed_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel_r != 2'h0) |=> (multi_speed_sel == 3'h0))
    else $error("multi-speed select active with remote mode");

  a_run_save: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == rss_pkg::RSS_LIVE && store_mode && run_fell)
      |=> (nvm_write_strobe && nvm_write_data == $past(set_speed)))
    else $error("run drop did not save setpoint");

  a_no_store2: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel_r != 2'h1) |=> !nvm_write_strobe)
    else $error("setpoint written outside storage mode");

  a_write_diff: assert property (@(posedge hclk) disable iff (!hresetn)
    (nvm_write_strobe && !$past(run_fell)) |-> ($past(set_speed) != $past(stored_r)))
    else $error("periodic write without change");

  a_minute_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    (speed_up_input || speed_down_input) && !run_fell |=> !nvm_write_strobe)
    else $error("periodic write while ramp input active");

  a_clamp_max: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == rss_pkg::RSS_LIVE && !(remote_act && setpoint_clear_input)
     && set_speed > max_r) |=> (set_speed == $past(max_r)))
    else $error("setpoint not clamped to maximum");

  a_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == rss_pkg::RSS_LIVE && remote_act && setpoint_clear_input)
      |=> (set_speed == 16'h0000))
    else $error("clear did not zero setpoint");

  a_cmd_sum: assert property (@(posedge hclk) disable iff (!hresetn)
    (!sum[16]) |=> (speed_command == $past(sum[15:0])))
    else $error("speed command is not setpoint plus compensation");

  a_hold_inact: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == rss_pkg::RSS_LIVE && !remote_act && set_speed <= max_r)
      |=> $stable(set_speed))
    else $error("setpoint moved while remote setting inactive");

  a_out_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (output_speed != $past(output_speed)) |-> $past(tick))
    else $error("output speed moved off a tick");

  a_boot_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_r == rss_pkg::RSS_BOOT && nvm_stored_value <= max_r)
      |=> (set_speed == $past(nvm_stored_value)))
    else $error("stored setpoint not restored");
endmodule : rss_top
`default_nettype wire

// ==== testbench/rss_switch_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Contact switches, run commands and non-volatile cell
module rss_switch_model (
  input  wire logic        hclk,
  input  wire logic        up_req,
  input  wire logic        dn_req,
  input  wire logic        clr_req,
  input  wire logic        fwd_req,
  input  wire logic        rev_req,
  input  wire logic        nvm_write_strobe,
  input  wire logic [15:0] nvm_write_data,
  output logic             speed_up_input,
  output logic             speed_down_input,
  output logic             setpoint_clear_input,
  output logic             forward_run_cmd,
  output logic             reverse_run_cmd,
  output logic      [15:0] nvm_stored_value
);
  initial begin
    speed_up_input = 1'b0;
    speed_down_input = 1'b0;
    setpoint_clear_input = 1'b0;
    forward_run_cmd = 1'b0;
    reverse_run_cmd = 1'b0;
    nvm_stored_value = 16'h0000;
  end
  // ==========================================================
  // Switch levels
  // Contacts move only on the clock, so no edge lands mid-cycle
  always @(posedge hclk) begin
    speed_up_input <= up_req;
    speed_down_input <= dn_req;
    setpoint_clear_input <= clr_req;
    forward_run_cmd <= fwd_req;
    reverse_run_cmd <= rev_req;
  end
  // ==========================================================
  // Memory cell
  // Not tied to reset: the value outlives a power cycle
  always @(posedge hclk) begin
    if (nvm_write_strobe === 1'b1) begin
      nvm_stored_value <= nvm_write_data;
    end
  end
endmodule : rss_switch_model
`default_nettype wire

// ==== testbench/rss_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module rss_top_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        up_req, dn_req, clr_req, fwd_req, rev_req;
  logic        speed_up_input, speed_down_input, setpoint_clear_input;
  logic        forward_run_cmd, reverse_run_cmd;
  logic        jog_operation, closed_loop_process_control;
  logic [15:0] analog_speed_cmd, nvm_stored_value;
  logic [2:0]  multi_speed_sel;
  logic        nvm_write_strobe;
  logic [15:0] nvm_write_data, speed_command, output_speed;
  int          fails, tests_run, cycles;

  assign hready = hreadyout;
  // Short tick and minute keep the run brief
  rss_top #(.TICK_CYCLES(4), .MINUTE_TICKS(5)) rss_top_i (
    .hclk                        (hclk),
    .hresetn                     (hresetn),
    .hsel                        (hsel),
    .haddr                       (haddr),
    .htrans                      (htrans),
    .hwrite                      (hwrite),
    .hsize                       (hsize),
    .hwdata                      (hwdata),
    .hready                      (hready),
    .hrdata                      (hrdata),
    .hreadyout                   (hreadyout),
    .hresp                       (hresp),
    .speed_up_input              (speed_up_input),
    .speed_down_input            (speed_down_input),
    .setpoint_clear_input        (setpoint_clear_input),
    .forward_run_cmd             (forward_run_cmd),
    .reverse_run_cmd             (reverse_run_cmd),
    .jog_operation               (jog_operation),
    .closed_loop_process_control (closed_loop_process_control),
    .analog_speed_cmd            (analog_speed_cmd),
    .nvm_stored_value            (nvm_stored_value),
    .multi_speed_sel             (multi_speed_sel),
    .nvm_write_strobe            (nvm_write_strobe),
    .nvm_write_data              (nvm_write_data),
    .speed_command               (speed_command),
    .output_speed                (output_speed)
  );
  rss_switch_model rss_switch_model_i (
    .hclk                 (hclk),
    .up_req               (up_req),
    .dn_req               (dn_req),
    .clr_req              (clr_req),
    .fwd_req              (fwd_req),
    .rev_req              (rev_req),
    .nvm_write_strobe     (nvm_write_strobe),
    .nvm_write_data       (nvm_write_data),
    .speed_up_input       (speed_up_input),
    .speed_down_input     (speed_down_input),
    .setpoint_clear_input (setpoint_clear_input),
    .forward_run_cmd      (forward_run_cmd),
    .reverse_run_cmd      (reverse_run_cmd),
    .nvm_stored_value     (nvm_stored_value)
  );

  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  // ==========================================================
  // Verdict and hang guard
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict;
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask : hold

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask : rdchk

  task automatic chk_set(input logic [15:0] e);
    logic [31:0] x;
    ahb(1'b0, 32'h1C, 32'h0, x);
    chk("set_speed", {16'h0, e}, {16'h0, x[15:0]});
  endtask : chk_set

  task automatic wait_save(input int n, input logic se, input logic [15:0] de);
    logic        seen;
    logic [15:0] d;
    seen = 1'b0;
    d = 16'h0000;
    repeat (n) begin
      @(posedge hclk);
      if (nvm_write_strobe === 1'b1 && !seen) begin
        seen = 1'b1;
        d = nvm_write_data;
      end
    end
    chk("nvm_write_strobe", {31'h0, se}, {31'h0, seen});
    if (se) chk("nvm_write_data", {16'h0, de}, {16'h0, d});
  endtask : wait_save

  // Fast ramps and a small maximum make clamping visible
  task automatic cfg;
    wr(32'h08, 32'h0);
    wr(32'h0C, 32'h0);
    wr(32'h10, 32'h0);
    wr(32'h14, 32'h0);
    wr(32'h04, 32'h3);
  endtask : cfg

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdchk("ctrl", 32'h00, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    rdchk("max", 32'h04, 32'h05DC);
    rdchk("sp_acc", 32'h08, 32'h5);
    rdchk("out_dec", 32'h14, 32'h5);
    rdchk("stored", 32'h20, 32'h0);
    wr(32'h80, 32'hFFFF);
    rdchk("unmapped", 32'h80, 32'h0);
    cfg;
  endtask : t_regs

  task automatic t_remap;
    up_req <= 1'b1;
    hold(4);
    chk("multi_speed_sel", 32'h4, {29'h0, multi_speed_sel});
    wr(32'h00, 32'h1);
    hold(2);
    chk("multi_speed_sel", 32'h0, {29'h0, multi_speed_sel});
    hold(40);
    chk_set(16'h0003);
    up_req <= 1'b0;
    wait_save(40, 1'b1, 16'h0003);
    wait_save(60, 1'b0, 16'h0000);
    clr_req <= 1'b1;
    hold(3);
    clr_req <= 1'b0;
    chk_set(16'h0000);
    wait_save(40, 1'b1, 16'h0000);
  endtask : t_remap

  task automatic t_rundrop_resume;
    fwd_req <= 1'b1;
    up_req <= 1'b1;
    hold(40);
    up_req <= 1'b0;
    fwd_req <= 1'b0;
    wait_save(8, 1'b1, 16'h0003);
    clr_req <= 1'b1;
    hold(3);
    clr_req <= 1'b0;
    hresetn <= 1'b0;
    hold(2);
    hresetn <= 1'b1;
    hold(2);
    chk_set(16'h0003);
    rdchk("stored", 32'h20, 32'h3);
  endtask : t_rundrop_resume

  task automatic t_nostore;
    cfg;
    // Lowering the maximum below the restored setpoint must pull it down
    wr(32'h04, 32'h2);
    hold(2);
    chk_set(16'h0002);
    wr(32'h04, 32'h3);
    wr(32'h00, 32'h2);
    rev_req <= 1'b1;
    dn_req <= 1'b1;
    hold(40);
    chk_set(16'h0000);
    dn_req <= 1'b0;
    rev_req <= 1'b0;
    wait_save(60, 1'b0, 16'h0000);
    wr(32'h00, 32'h3);
    fwd_req <= 1'b1;
    hold(3);
    fwd_req <= 1'b0;
    wait_save(8, 1'b0, 16'h0000);
  endtask : t_nostore

  task automatic t_cmd;
    int k;
    wr(32'h00, 32'h1);
    up_req <= 1'b1;
    hold(40);
    up_req <= 1'b0;
    analog_speed_cmd <= 16'h0100;
    hold(3);
    chk("speed_command", 32'h103, {16'h0, speed_command});
    chk("output_lags", 32'h1, {31'h0, output_speed < 16'h0103});
    k = 0;
    while (output_speed !== 16'h0103 && k < 2000) begin
      @(posedge hclk);
      k++;
    end
    chk("output_speed", 32'h103, {16'h0, output_speed});
    wr(32'h00, 32'h5);
    wr(32'h18, 32'h20);
    hold(3);
    chk("speed_command", 32'h23, {16'h0, speed_command});
    jog_operation <= 1'b1;
    hold(3);
    chk("speed_command", 32'h20, {16'h0, speed_command});
    jog_operation <= 1'b0;
    closed_loop_process_control <= 1'b1;
    hold(3);
    chk("speed_command", 32'h20, {16'h0, speed_command});
    closed_loop_process_control <= 1'b0;
  endtask : t_cmd

  // ==========================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, up_req, dn_req, clr_req, fwd_req, rev_req} = '0;
    {jog_operation, closed_loop_process_control} = '0;
    {haddr, hwdata, htrans, analog_speed_cmd} = '0;
    hsize = 3'h2;
    {fails, tests_run, cycles} = '0;
    hold(6);
    hresetn <= 1'b1;
    hold(1);
    t_regs;
    t_remap;
    t_rundrop_resume;
    t_nostore;
    t_cmd;
    give_verdict;
  end
endmodule : rss_top_tb
`default_nettype wire
